//--- core/fcs_seq.v
// flash command sequencer: apb registers, order checking, op timing
//
// Local design decisions: the APB interface to the registers and the address map.
`timescale 1ns/10ps
`include "fcs_defs.vh"

// ----------------------------------------
// ----------------------------------------
module fcs_seq
#(
   parameter PAGES = 32
)
(
   input  wire        core_clk,
   input  wire        rst,
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [11:0] paddr,
   input  wire [31:0] pwdata,
   output reg  [31:0] prdata,
   output wire        pready,
   output wire        pslverr,
   input  wire        stop_mode,
   output reg         op_start_r,
   output reg  [7:0]  op_cmd_r,
   output reg  [13:0] op_addr_r,
   output reg  [7:0]  op_data_r,
   output wire        op_busy
);
   localparam AW = (PAGES > 16) ? 14 : 13;
   // small array: top address bit forced low so latches never alias
   localparam [13:0] AMASK = (14'h0001 << AW) - 14'h0001;

   localparam S_IDLE = 2'h0;
   localparam S_ADDR = 2'h1;
   localparam S_CMD  = 2'h2;

   reg  [1:0]  state_r;
   reg  [1:0]  state_nxt;
   reg         div_loaded_r;
   reg  [6:0]  div_val_r;
   reg         accerr_r;
   reg         ccf_r;
   reg         blank_r;
   reg  [13:0] lat_addr_r;
   reg  [7:0]  lat_data_r;
   reg  [7:0]  lat_cmd_r;
   reg  [13:0] prev_addr_r;
   reg         prev_burst_r;
   reg  [13:0] addr_arg_r;
   reg  [15:0] cycles_r;
   reg         err_set;
   reg         launch;

   wire        tick;
   wire        done;
   wire        busy;

   wire wr = psel && penable && pwrite;
   wire w_div  = wr && (paddr == `FCS_OFF_DIV);
   wire w_stat = wr && (paddr == `FCS_OFF_STAT);
   wire w_cmd  = wr && (paddr == `FCS_OFF_CMD);
   wire w_arr  = wr && (paddr == `FCS_OFF_ARR_DATA);
   wire w_aadr = wr && (paddr == `FCS_OFF_ARR_ADDR);
   wire cbef   = (state_r == S_IDLE) && !busy;
   wire arr_take = (state_r == S_IDLE) && (state_nxt == S_ADDR);
   wire cmd_take = (state_r == S_ADDR) && (state_nxt == S_CMD);

   function legal_code;
      input [7:0] c;
      begin
         legal_code = (c == `FCS_CMD_BLANK) || (c == `FCS_CMD_BYTE) ||
                      (c == `FCS_CMD_BURST) || (c == `FCS_CMD_PAGE) ||
                      (c == `FCS_CMD_MASS);
      end
   endfunction

   function mapped;
      input [11:0] a;
      begin
         mapped = (a == `FCS_OFF_DIV) || (a == `FCS_OFF_STAT) ||
                  (a == `FCS_OFF_CMD) || (a == `FCS_OFF_ARR_ADDR) ||
                  (a == `FCS_OFF_ARR_DATA);
      end
   endfunction

   assign pready  = 1'b1;
   assign pslverr = psel && penable && !mapped(paddr);
   assign op_busy = busy;

   // ----------------------------------------
   // timing clock and op timer
   // ----------------------------------------
   fcs_tick_gen u_tick
   (
      .core_clk (core_clk),
      .rst      (rst),
      .enable   (div_loaded_r),
      .div_val  (div_val_r),
      .tick_r   (tick)
   );

   fcs_op_timer u_timer
   (
      .core_clk (core_clk),
      .rst      (rst),
      .start    (launch),
      .abort    (stop_mode && busy),
      .cycles   (cycles_r),
      .tick     (tick),
      .busy_r   (busy),
      .done     (done)
   );

   // ----------------------------------------
   // sequence checking
   // ----------------------------------------
   always @*
   begin
      state_nxt = state_r;
      err_set   = 1'b0;
      launch    = 1'b0;
      if (stop_mode && busy)
         err_set = 1'b1;
      case (state_r)
         S_IDLE:
         begin
            if (w_arr)
            begin
               if (!div_loaded_r || accerr_r || busy)
                  err_set = 1'b1;
               else
                  state_nxt = S_ADDR;
            end
         end
         S_ADDR:
         begin
            if (w_cmd)
            begin
               if (legal_code(pwdata[7:0]))
                  state_nxt = S_CMD;
               else
               begin
                  err_set   = 1'b1;
                  state_nxt = S_IDLE;
               end
            end
            else if (w_arr || w_div || w_stat)
            begin
               err_set   = 1'b1;
               state_nxt = S_IDLE;
            end
         end
         S_CMD:
         begin
            if (w_stat && pwdata[`FCS_STAT_CBEF])
            begin
               launch    = 1'b1;
               state_nxt = S_IDLE;
            end
            else if (w_stat || w_arr || w_cmd || w_div)
            begin
               err_set   = 1'b1;
               state_nxt = S_IDLE;
            end
         end
         default:
            state_nxt = S_IDLE;
      endcase
   end

   // ----------------------------------------
   // command argument and cycle count
   // ----------------------------------------
   always @*
   begin
      addr_arg_r = lat_addr_r;
      cycles_r   = `FCS_CYC_BYTE;
      case (lat_cmd_r)
         `FCS_CMD_PAGE:
         begin
            addr_arg_r = {lat_addr_r[13:9], 9'h000};
            cycles_r   = `FCS_CYC_PAGE;
         end
         `FCS_CMD_MASS:
            cycles_r = `FCS_CYC_MASS;
         `FCS_CMD_BLANK:
            cycles_r = `FCS_CYC_BLANK;
         `FCS_CMD_BURST:
            // same row, consecutive burst: short time; new row: full
            cycles_r = (prev_burst_r &&
                        lat_addr_r == prev_addr_r + 14'h0001 &&
                        lat_addr_r[5:0] != 6'h00) ?
                       `FCS_CYC_BURST : `FCS_CYC_BYTE;
         default:
            cycles_r = `FCS_CYC_BYTE;
      endcase
   end

   // ----------------------------------------
   // divider, written once per reset
   // ----------------------------------------
   always @(posedge core_clk)
   begin
      if (rst)
      begin
         div_loaded_r <= 1'b0;
         div_val_r    <= 7'h00;
      end
      else if (w_div && !div_loaded_r && !accerr_r)
      begin
         div_loaded_r <= 1'b1;
         div_val_r    <= pwdata[6:0];
      end
   end

   // ----------------------------------------
   // access error flag
   // ----------------------------------------
   always @(posedge core_clk)
   begin
      if (rst)
         accerr_r <= 1'b0;
      // a new error wins over a software clear in the same cycle
      else if (err_set)
         accerr_r <= 1'b1;
      else if (w_stat && pwdata[`FCS_STAT_ACCERR])
         accerr_r <= 1'b0;
   end

   // ----------------------------------------
   // sequence state and command latches
   // ----------------------------------------
   always @(posedge core_clk)
   begin
      if (rst)
      begin
         state_r    <= S_IDLE;
         lat_addr_r <= 14'h0000;
         lat_data_r <= 8'h00;
         lat_cmd_r  <= 8'h00;
      end
      else
      begin
         state_r <= state_nxt;
         if (arr_take)
         begin
            lat_addr_r <= pwdata[8 +: 14] & AMASK;
            lat_data_r <= pwdata[7:0];
         end
         if (cmd_take)
            lat_cmd_r <= pwdata[7:0];
      end
   end

   // ----------------------------------------
   // launched operation and status flags
   // ----------------------------------------
   always @(posedge core_clk)
   begin
      if (rst)
      begin
         ccf_r        <= 1'b1;
         blank_r      <= 1'b0;
         prev_addr_r  <= 14'h0000;
         prev_burst_r <= 1'b0;
         op_start_r   <= 1'b0;
         op_cmd_r     <= 8'h00;
         op_addr_r    <= 14'h0000;
         op_data_r    <= 8'h00;
      end
      else
      begin
         op_start_r <= launch;
         if (launch)
         begin
            ccf_r        <= 1'b0;
            op_cmd_r     <= lat_cmd_r;
            op_addr_r    <= addr_arg_r;
            op_data_r    <= lat_data_r;
            prev_addr_r  <= lat_addr_r;
            prev_burst_r <= (lat_cmd_r == `FCS_CMD_BURST);
            blank_r      <= 1'b0;
         end
         else if (done)
         begin
            ccf_r   <= 1'b1;
            blank_r <= (op_cmd_r == `FCS_CMD_BLANK);
         end
         else if (stop_mode && busy)
         begin
            // abort drops high voltage, so the next burst byte is full
            ccf_r        <= 1'b1;
            prev_burst_r <= 1'b0;
         end
      end
   end

   // ----------------------------------------
   // read data
   // ----------------------------------------
   always @*
   begin
      prdata = 32'h0000_0000;
      case (paddr)
         `FCS_OFF_DIV:
            prdata = {24'h0, div_loaded_r, div_val_r};
         `FCS_OFF_STAT:
            prdata = {24'h0, cbef, ccf_r, 1'b0, accerr_r, 1'b0,
                      blank_r, 2'h0};
         `FCS_OFF_CMD:
            prdata = {24'h0, lat_cmd_r};
         `FCS_OFF_ARR_ADDR:
            prdata = {18'h0, lat_addr_r};
         `FCS_OFF_ARR_DATA:
            prdata = {24'h0, lat_data_r};
         default:
            prdata = 32'h0000_0000;
      endcase
   end
endmodule // fcs_seq

//--- core/fcs_defs.vh
// register offsets, field positions, command codes and timing counts
`ifndef FCS_DEFS_VH
`define FCS_DEFS_VH
`define FCS_OFF_DIV        12'h000
`define FCS_OFF_STAT       12'h004
`define FCS_OFF_CMD        12'h008
`define FCS_OFF_ARR_ADDR   12'h00c
`define FCS_OFF_ARR_DATA   12'h010
`define FCS_STAT_CBEF      7
`define FCS_STAT_CCF       6
`define FCS_STAT_ACCERR    4
`define FCS_STAT_BLANK     2
`define FCS_DIV_LOADED     7
`define FCS_CMD_BLANK      8'h05
`define FCS_CMD_BYTE       8'h20
`define FCS_CMD_BURST      8'h25
`define FCS_CMD_PAGE       8'h40
`define FCS_CMD_MASS       8'h41
`define FCS_CYC_BYTE       16'h0009
`define FCS_CYC_BURST      16'h0004
`define FCS_CYC_PAGE       16'h0fa0
`define FCS_CYC_MASS       16'h4e20
`define FCS_CYC_BLANK      16'h0001
`endif

//--- core/fcs_tick_gen.v
// timing clock tick generator from the bus clock
`timescale 1ns/10ps
module fcs_tick_gen
(
   input  wire       core_clk,
   input  wire       rst,
   input  wire       enable,
   input  wire [6:0] div_val,
   output reg        tick_r
);
   reg [9:0] cnt_r;
   wire [9:0] limit = {3'h0, div_val} + 10'h001;

   // ----------------------------------------
   // divider
   // ----------------------------------------
   always @(posedge core_clk)
   begin
      if (rst)
      begin
         cnt_r  <= 10'h000;
         tick_r <= 1'b0;
      end
      else if (!enable)
      begin
         cnt_r  <= 10'h000;
         tick_r <= 1'b0;
      end
      else if (cnt_r >= limit - 10'h001)
      begin
         cnt_r  <= 10'h000;
         tick_r <= 1'b1;
      end
      else
      begin
         cnt_r  <= cnt_r + 10'h001;
         tick_r <= 1'b0;
      end
   end
endmodule // fcs_tick_gen

//--- core/fcs_op_timer.v
// counts timing-clock ticks for one array operation
`timescale 1ns/10ps
module fcs_op_timer
(
   input  wire        core_clk,
   input  wire        rst,
   input  wire        start,
   input  wire        abort,
   input  wire [15:0] cycles,
   input  wire        tick,
   output reg         busy_r,
   output wire        done
);
   reg [15:0] left_r;

   assign done = busy_r && tick && (left_r == 16'h0001);

   // ----------------------------------------
   // countdown
   // ----------------------------------------
   always @(posedge core_clk)
   begin
      if (rst || abort)
      begin
         busy_r <= 1'b0;
         left_r <= 16'h0000;
      end
      else if (start)
      begin
         busy_r <= 1'b1;
         left_r <= cycles;
      end
      else if (busy_r && tick)
      begin
         left_r <= left_r - 16'h0001;
         if (left_r == 16'h0001)
            busy_r <= 1'b0;
      end
   end
endmodule // fcs_op_timer

//--- tb/fcs_seq_properties.sv
// port assertions for the flash command sequencer
`timescale 1ns/10ps
`include "fcs_defs.vh"
module fcs_seq_chk
(
   input wire        core_clk,
   input wire        rst,
   input wire        psel,
   input wire        penable,
   input wire        pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   input wire        pslverr,
   input wire        stop_mode,
   input wire        op_start_r,
   input wire [7:0]  op_cmd_r,
   input wire [13:0] op_addr_r,
   input wire        op_busy
);
default clocking @(posedge core_clk); endclocking
default disable iff (rst);
sequence pulse_s;
   op_start_r ##1 !op_start_r;
endsequence
launch_cause_a: assert property (op_start_r |-> $past(psel && penable &&
   pwrite && paddr == `FCS_OFF_STAT && pwdata[7]))
   else $error("start without launch write");
start_pulse_a: assert property (op_start_r |-> pulse_s)
   else $error("start pulse too long");
start_busy_a: assert property (op_start_r |-> op_busy)
   else $error("start without busy");
busy_cause_a: assert property ($rose(op_busy) |-> op_start_r)
   else $error("busy without start");
legal_code_a: assert property (op_start_r |-> op_cmd_r inside
   {8'h05, 8'h20, 8'h25, 8'h40, 8'h41})
   else $error("illegal code started");
page_align_a: assert property (op_start_r && op_cmd_r == 8'h40
   |-> op_addr_r[8:0] == 9'h000)
   else $error("page erase address not aligned");
stop_abort_a: assert property (op_busy && stop_mode
   |-> ##[1:4] !op_busy)
   else $error("stop mode did not abort");
cmd_mapped_a: assert property (psel && penable && paddr == `FCS_OFF_CMD
   |-> !pslverr)
   else $error("mapped address flagged");
endmodule // fcs_seq_chk
bind fcs_seq fcs_seq_chk u_chk (.core_clk(core_clk), .rst(rst),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
   .pwdata(pwdata), .pslverr(pslverr), .stop_mode(stop_mode),
   .op_start_r(op_start_r), .op_cmd_r(op_cmd_r), .op_addr_r(op_addr_r),
   .op_busy(op_busy));

//--- tb/fcs_seq_tb.sv
// self-checking bench for the flash command sequencer
`timescale 1ns/10ps
`include "fcs_defs.vh"
module fcs_seq_tb;
   reg         core_clk, rst, psel, penable, pwrite, stop_mode, se;
   reg  [11:0] paddr;
   reg  [31:0] pwdata, rv;
   wire [31:0] prdata;
   wire        pready, pslverr, op_start_r, op_busy;
   wire [7:0]  op_cmd_r, op_data_r;
   wire [13:0] op_addr_r;
   reg  [7:0]  s_cmd, s_dat, dt, c;
   reg  [13:0] s_adr, a;
   integer     num_errors, samples_checked, seed, n, i, e, starts;
   reg  [21:0] exp_q[$];
   reg  [21:0] ex;
   fcs_seq DUT (.core_clk(core_clk), .rst(rst), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .stop_mode(stop_mode), .op_start_r(op_start_r), .op_cmd_r(op_cmd_r),
      .op_addr_r(op_addr_r), .op_data_r(op_data_r), .op_busy(op_busy));
   initial
   begin
      core_clk = 0;
      forever #20 core_clk = ~core_clk;
   end
   always @(posedge core_clk)
      if (op_start_r === 1'b1)
      begin
         s_cmd = op_cmd_r;
         s_adr = op_addr_r;
         s_dat = op_data_r;
         starts = starts + 1;
         if (exp_q.size() == 0)
            chk(1, 0);
         else
         begin
            ex = exp_q.pop_front();
            chk({op_cmd_r, op_addr_r}, ex);
         end
      end
   task chk(input [31:0] got, input [31:0] exp);
   begin
      samples_checked = samples_checked + 1;
      if (got !== exp)
      begin
         num_errors = num_errors + 1;
         $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
      end
   end
   endtask
   task finish_test;
   begin
      if (num_errors == 0 && samples_checked > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   end
   endtask
   // prdata is read at the accepting edge, before that edge's updates
   task apb(input w, input [11:0] ad, input [31:0] wd);
   begin
      psel <= 1;
      penable <= 0;
      pwrite <= w;
      paddr <= ad;
      pwdata <= wd;
      @(posedge core_clk);
      penable <= 1;
      @(posedge core_clk);
      while (pready !== 1'b1)
         @(posedge core_clk);
      rv = prdata;
      se = pslverr;
      psel <= 0;
      penable <= 0;
      @(posedge core_clk);
   end
   endtask
   task seq(input [7:0] cc, input [31:0] st);
   begin
      apb(1, `FCS_OFF_ARR_DATA, {10'h000, a, dt});
      apb(1, `FCS_OFF_CMD, {24'h000000, cc});
      apb(1, `FCS_OFF_STAT, st);
   end
   endtask
   task err_clr;
   begin
      apb(0, `FCS_OFF_STAT, 0);
      chk(rv[4], 1);
      apb(1, `FCS_OFF_STAT, 32'h10);
      apb(0, `FCS_OFF_STAT, 0);
      chk(rv[4], 0);
   end
   endtask
   initial
   begin
      #3600000;
      num_errors = num_errors + 1;
      finish_test;
   end
   initial
   begin
      {psel, penable, pwrite, stop_mode, paddr, pwdata} = 0;
      {num_errors, samples_checked, starts} = 0;
      seed = 98442;
      rst = 1;
      repeat (4) @(posedge core_clk);
      rst <= 0;
      @(posedge core_clk);
      apb(0, `FCS_OFF_STAT, 0);
      chk(rv[7:0] & 8'hd0, 8'hc0);
      apb(1, `FCS_OFF_ARR_DATA, 0);
      apb(1, `FCS_OFF_DIV, 1);
      apb(0, `FCS_OFF_DIV, 0);
      chk(rv[7], 0);
      err_clr;
      apb(1, `FCS_OFF_DIV, 1);
      apb(1, `FCS_OFF_DIV, 5);
      apb(0, `FCS_OFF_DIV, 0);
      chk(rv[7:0], 8'h81);
      // tick every two bus clocks keeps the mass erase short
      for (i = 0; i < 6; i = i + 1)
      begin
         dt = $random(seed);
         if (i != 3)
            a = $random(seed) & 14'h3ffe;
         else
            a = a + 1;
         case (i)
            0: {c, e} = {`FCS_CMD_BLANK, 32'd1};
            1: {c, e} = {`FCS_CMD_BYTE, 32'd9};
            2: {c, e} = {`FCS_CMD_BURST, 32'd9};
            3: {c, e} = {`FCS_CMD_BURST, 32'd4};
            4: {c, e} = {`FCS_CMD_PAGE, 32'd4000};
            default: {c, e} = {`FCS_CMD_MASS, 32'd20000};
         endcase
         exp_q.push_back({c, c == `FCS_CMD_PAGE ? a & 14'h3e00 : a});
         seq(c, 32'h80);
         n = 1;
         if (i > 1)
         begin
            apb(0, `FCS_OFF_STAT, 0);
            chk(rv[7:6], 0);
            n = 4;
         end
         while (op_busy === 1'b1 && n < 50000)
         begin
            @(posedge core_clk);
            n = n + 1;
         end
         chk(n > 2 * e - 5 && n < 2 * e + 5, 1);
         chk(s_cmd, c);
         chk(s_adr, c == `FCS_CMD_PAGE ? a & 14'h3e00 : a);
         if (i == 1 || i == 2)
            chk(s_dat, dt);
         apb(0, `FCS_OFF_STAT, 0);
         chk(rv[7:0] & 8'hd4, i == 0 ? 8'hc4 : 8'hc0);
      end
      apb(0, `FCS_OFF_ARR_ADDR, 0);
      chk(rv, {18'h0, a});
      apb(0, `FCS_OFF_ARR_DATA, 0);
      chk(rv, {24'h0, dt});
      apb(0, `FCS_OFF_CMD, 0);
      chk(rv, {24'h0, `FCS_CMD_MASS});
      n = starts;
      seq(8'h33, 32'h80);
      seq(`FCS_CMD_BYTE, 32'h80);
      chk(starts, n);
      err_clr;
      seq(`FCS_CMD_BYTE, 32'h00);
      err_clr;
      apb(1, `FCS_OFF_ARR_DATA, 0);
      apb(1, `FCS_OFF_ARR_DATA, 0);
      err_clr;
      apb(0, 12'h020, 0);
      chk(se, 1);
      exp_q.push_back({`FCS_CMD_MASS, a});
      seq(`FCS_CMD_MASS, 32'h80);
      apb(1, `FCS_OFF_ARR_DATA, 0);
      err_clr;
      chk(op_busy, 1);
      repeat (20) @(posedge core_clk);
      stop_mode <= 1;
      repeat (6) @(posedge core_clk);
      chk(op_busy, 0);
      stop_mode <= 0;
      err_clr;
      rst <= 1;
      repeat (2) @(posedge core_clk);
      rst <= 0;
      @(posedge core_clk);
      apb(0, `FCS_OFF_STAT, 0);
      chk(rv[7:0] & 8'hd4, 8'hc0);
      apb(1, `FCS_OFF_DIV, 3);
      apb(0, `FCS_OFF_DIV, 0);
      chk(rv[7:0], 8'h83);
      chk(exp_q.size(), 0);
      finish_test;
   end
endmodule // fcs_seq_tb
